/* File: verilog/uart_aux_irq_timer_ctrl.sv */
// Auxiliary control: counter/timer, interrupt status and output pin select
`timescale 1ns/1ps
module uart_aux_irq_timer_ctrl
  import aux_timer_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // CPU register port
  input wire logic [3:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  output logic [7:0] cpu_rdata_o,
  // Input pins 0 to 3
  input wire logic [3:0] input_pin_i,
  // Channel status from the serial cores
  input wire logic ch_a_tx_ready_i,
  input wire logic ch_b_tx_ready_i,
  input wire logic ch_a_break_edge_i,
  input wire logic ch_b_break_edge_i,
  input wire logic ch_a_break_clr_i,
  input wire logic ch_b_break_clr_i,
  input wire logic ch_a_rx_push_i,
  input wire logic ch_b_rx_push_i,
  input wire logic ch_a_rx_pop_i,
  input wire logic ch_b_rx_pop_i,
  input wire logic ch_a_fifo_full_i,
  input wire logic ch_b_fifo_full_i,
  input wire logic ch_a_fifo_nonempty_i,
  input wire logic ch_b_fifo_nonempty_i,
  input wire logic ch_a_full_mode_i,
  input wire logic ch_b_full_mode_i,
  // Channel clocks from the serial cores
  input wire logic ch_a_tx16_clk_i,
  input wire logic ch_a_tx1_clk_i,
  input wire logic ch_a_rx1_clk_i,
  input wire logic ch_b_tx1_clk_i,
  input wire logic ch_b_rx1_clk_i,
  // Interrupt and pins
  output logic interrupt_out_n_o,
  output logic [2:0] output_pin_o,
  output logic [2:0] output_pin_oe_o,
  output logic [7:0] output_register_o,
  // Baud-rate generator set
  output logic baud_set_two_o
);

  // ----------------------------------------------------------------
  // Local functions
  // ----------------------------------------------------------------

  // Sticky flag update; a set in the clearing cycle wins
  function automatic logic sticky(input logic q, input logic set, input logic clr);
    sticky = set | (q & ~clr);
  endfunction

  // Receive status set term for one channel
  function automatic logic rx_set(input logic push, input logic full,
                                  input logic full_mode, input logic popped,
                                  input logic nonempty);
    rx_set = full_mode ? (push & full) : (push | (popped & nonempty));
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_q; // Two-stage release of the reset
  logic rst_n; // Synchronously released reset

  // Assert at once, release after two edges
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // ----------------------------------------------------------------
  // Input pin synchronisation
  // ----------------------------------------------------------------
  pin_sense_if sense ();

  input_change_detect u_detect (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pin_i(input_pin_i),
    .sense(sense.src)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_aux = cpu_wr_i & (cpu_addr_i == ADDR_AUX_CTRL);
  wire wr_mask = cpu_wr_i & (cpu_addr_i == ADDR_IRQ_MASK);
  wire wr_pre_up = cpu_wr_i & (cpu_addr_i == ADDR_PRESET_UP);
  wire wr_pre_lo = cpu_wr_i & (cpu_addr_i == ADDR_PRESET_LO);
  wire wr_sel = cpu_wr_i & (cpu_addr_i == ADDR_PIN_SEL);
  wire wr_oset = cpu_wr_i & (cpu_addr_i == ADDR_OUT_SET);
  wire wr_oclr = cpu_wr_i & (cpu_addr_i == ADDR_OUT_CLR);
  wire rd_change = cpu_rd_i & (cpu_addr_i == ADDR_IN_CHANGE);
  wire ct_start = cpu_rd_i & (cpu_addr_i == ADDR_CT_START);
  wire ct_stop = cpu_rd_i & (cpu_addr_i == ADDR_CT_STOP);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] aux_q; // auxiliary_control
  logic [7:0] mask_q; // interrupt_mask
  logic [7:0] sel_q; // output_pin_source_select
  logic [7:0] opr_q; // output_register
  logic [15:0] preset_q; // Preset, write-only to the CPU

  // Plain stores; the output register takes set and clear masks
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_q <= AUX_CTRL_RST;
      mask_q <= IRQ_MASK_RST;
      sel_q <= PIN_SEL_RST;
      opr_q <= OUT_REG_RST;
      preset_q <= PRESET_RST;
    end else begin
      if (wr_aux) begin
        aux_q <= cpu_wdata_i;
      end
      if (wr_mask) begin
        mask_q <= cpu_wdata_i;
      end
      if (wr_sel) begin
        sel_q <= cpu_wdata_i;
      end
      if (wr_oset) begin
        opr_q <= opr_q | cpu_wdata_i;
      end else if (wr_oclr) begin
        opr_q <= opr_q & ~cpu_wdata_i;
      end
      // No guard below two; software keeps the preset legal
      if (wr_pre_up) begin
        preset_q[15:8] <= cpu_wdata_i;
      end
      if (wr_pre_lo) begin
        preset_q[7:0] <= cpu_wdata_i;
      end
    end
  end

  assign baud_set_two_o = aux_q[AUX_BAUD_SET];
  assign output_register_o = opr_q;

  // ----------------------------------------------------------------
  // Counter/timer clock sources
  // ----------------------------------------------------------------
  logic [3:0] xtal_div_q; // Crystal divide-by-16
  logic [3:0] ip2_div_q; // Input pin 2 divide-by-16
  logic ip2_last_q; // Previous pin 2 level
  logic txa_last_q; // Previous channel A tx clock
  logic txb_last_q; // Previous channel B tx clock

  wire xtal16_tick = (xtal_div_q == PRESCALE_LAST);
  wire ip2_edge = sense.level[2] & ~ip2_last_q;
  wire ip2_16_tick = ip2_edge & (ip2_div_q == PRESCALE_LAST);
  wire txa_edge = ch_a_tx1_clk_i & ~txa_last_q;
  wire txb_edge = ch_b_tx1_clk_i & ~txb_last_q;

  // Each source becomes a one-cycle count enable
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xtal_div_q <= 4'h0;
      ip2_div_q <= 4'h0;
      ip2_last_q <= 1'b0;
      txa_last_q <= 1'b0;
      txb_last_q <= 1'b0;
    end else begin
      xtal_div_q <= xtal_div_q + 4'h1;
      ip2_div_q <= ip2_edge ? ip2_div_q + 4'h1 : ip2_div_q;
      ip2_last_q <= sense.level[2];
      txa_last_q <= ch_a_tx1_clk_i;
      txb_last_q <= ch_b_tx1_clk_i;
    end
  end

  // Index is the mode field; codes 0-3 count, 4-7 time
  wire [7:0] src_ticks = {xtal16_tick, 1'b1, ip2_16_tick, ip2_edge,
                          xtal16_tick, txb_edge, txa_edge, ip2_edge};
  wire ct_tick = src_ticks[aux_q[AUX_MODE_MSB:AUX_MODE_LSB]];
  wire is_timer = aux_q[AUX_MODE_MSB];

  // ----------------------------------------------------------------
  // Counter/timer core
  // ----------------------------------------------------------------
  logic [15:0] cnt_q; // Live count
  logic [15:0] cnt_d;
  logic sq_q; // Timer square wave
  logic sq_d;
  logic ct_out_q; // Counter-mode output, high until terminal count
  logic ct_out_d;
  ct_state_t ct_state_q; // Counter-mode run state
  ct_state_t ct_state_d;

  wire counting = (ct_state_q == CT_COUNTING);
  wire half_end = ct_tick & (cnt_q == CT_ONE); // Count reaches zero
  wire advance = ct_tick & (is_timer | counting); // Timer never stops
  wire term_cnt = ~is_timer & counting & half_end;
  wire timer_ready = is_timer & half_end & ~sq_q;

  // Timer reloads each half period, so a new preset waits its turn
  assign cnt_d = ct_start ? preset_q :
                 (advance & is_timer & half_end) ? preset_q :
                 advance ? cnt_q - CT_ONE : cnt_q;

  // Toggle once per half period for a period of twice the preset
  assign sq_d = ct_start ? 1'b1 :
                (is_timer & half_end) ? ~sq_q : sq_q;

  // Stop restores the high level; terminal count pulls it low
  assign ct_out_d = ct_stop ? 1'b1 :
                    term_cnt ? 1'b0 : ct_out_q;

  // Start runs the counter, stop halts it
  always_comb begin
    ct_state_d = ct_state_q;
    unique case (ct_state_q)
      CT_STOPPED: begin
        if (ct_start) begin
          ct_state_d = CT_COUNTING;
        end
      end
      CT_COUNTING: begin
        if (ct_stop) begin
          ct_state_d = CT_STOPPED;
        end
      end
      default: begin
        ct_state_d = CT_STOPPED;
      end
    endcase
  end

  // Counter/timer storage
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= PRESET_RST;
      sq_q <= 1'b1;
      ct_out_q <= 1'b1;
      ct_state_q <= CT_STOPPED;
    end else begin
      cnt_q <= cnt_d;
      sq_q <= sq_d;
      ct_out_q <= ct_out_d;
      ct_state_q <= ct_state_d;
    end
  end

  // ----------------------------------------------------------------
  // Input change register
  // ----------------------------------------------------------------
  logic [3:0] chg_q; // Latched changes on pins 3 to 0

  // A change in the reading cycle survives the clear
  wire [3:0] chg_d = sense.change | (chg_q & ~{4{rd_change}});

  // Change latch storage
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chg_q <= 4'h0;
    end else begin
      chg_q <= chg_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [7:0] stat_q; // Sticky status bits; tx ready bits unused here
  logic a_popped_q; // Channel A FIFO popped last cycle
  logic b_popped_q; // Channel B FIFO popped last cycle
  logic [7:0] stat_d;

  wire in_chg_set = |(sense.change & aux_q[3:0]);
  wire a_rx_set = rx_set(ch_a_rx_push_i, ch_a_fifo_full_i, ch_a_full_mode_i,
                         a_popped_q, ch_a_fifo_nonempty_i);
  wire b_rx_set = rx_set(ch_b_rx_push_i, ch_b_fifo_full_i, ch_b_full_mode_i,
                         b_popped_q, ch_b_fifo_nonempty_i);

  // Next status; every set wins over its clear
  always_comb begin
    stat_d = stat_q;
    stat_d[ST_IN_CHANGE] = sticky(stat_q[ST_IN_CHANGE], in_chg_set, rd_change);
    stat_d[ST_B_BREAK] = sticky(stat_q[ST_B_BREAK], ch_b_break_edge_i,
                                ch_b_break_clr_i);
    stat_d[ST_A_BREAK] = sticky(stat_q[ST_A_BREAK], ch_a_break_edge_i,
                                ch_a_break_clr_i);
    stat_d[ST_B_RX] = sticky(stat_q[ST_B_RX], b_rx_set, ch_b_rx_pop_i);
    stat_d[ST_A_RX] = sticky(stat_q[ST_A_RX], a_rx_set, ch_a_rx_pop_i);
    stat_d[ST_CT_READY] = sticky(stat_q[ST_CT_READY], timer_ready | term_cnt,
                                 ct_stop);
    stat_d[ST_B_TX] = 1'b0;
    stat_d[ST_A_TX] = 1'b0;
  end

  // Status storage, zero after reset
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= IRQ_STATUS_RST;
      a_popped_q <= 1'b0;
      b_popped_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      a_popped_q <= ch_a_rx_pop_i;
      b_popped_q <= ch_b_rx_pop_i;
    end
  end

  // Transmitter-ready bits follow the cores directly
  wire [7:0] status = {stat_q[7:5], ch_b_tx_ready_i, stat_q[3:1],
                       ch_a_tx_ready_i};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Count bytes read live; a carry between two reads can tear the value
  wire [7:0] rd_mux = (cpu_addr_i == ADDR_IN_CHANGE) ? {chg_q, sense.level} :
                      (cpu_addr_i == ADDR_IRQ_STATUS) ? status :
                      (cpu_addr_i == ADDR_VALUE_UP) ? cnt_q[15:8] :
                      (cpu_addr_i == ADDR_VALUE_LO) ? cnt_q[7:0] :
                      8'h00;

  // ----------------------------------------------------------------
  // Output pin sources
  // ----------------------------------------------------------------
  wire [1:0] sel3 = sel_q[SEL_PIN3_LSB+1:SEL_PIN3_LSB];
  wire [1:0] sel2 = sel_q[SEL_PIN2_LSB+1:SEL_PIN2_LSB];
  wire ct_pin = is_timer ? sq_q : ct_out_q;

  // Pin 4: unmasked receive status in open-collector form
  wire p4_val = sel_q[SEL_PIN4] ? ~stat_q[ST_A_RX] : ~opr_q[4];
  wire p4_oe = sel_q[SEL_PIN4] ? ~p4_val : 1'b1;

  // Pin 3: counter output is open-collector, clocks push-pull
  wire p3_val = (sel3 == 2'b00) ? ~opr_q[3] :
                (sel3 == 2'b01) ? ct_pin :
                (sel3 == 2'b10) ? ch_b_tx1_clk_i : ch_b_rx1_clk_i;
  wire p3_oe = (sel3 == 2'b01) ? ~ct_pin : 1'b1;

  // Pin 2: the 16X clock arrives already as 1X when the core says so
  wire p2_val = (sel2 == 2'b00) ? ~opr_q[2] :
                (sel2 == 2'b01) ? ch_a_tx16_clk_i :
                (sel2 == 2'b10) ? ch_a_tx1_clk_i : ch_a_rx1_clk_i;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Registered outputs add one cycle to forwarded clocks
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata_o <= 8'h00;
      interrupt_out_n_o <= 1'b1;
      output_pin_o <= 3'h7;
      output_pin_oe_o <= 3'h7;
    end else begin
      if (cpu_rd_i) begin
        cpu_rdata_o <= rd_mux;
      end
      interrupt_out_n_o <= ~|(status & mask_q);
      output_pin_o <= {p4_val, p3_val, p2_val};
      output_pin_oe_o <= {p4_oe, p3_oe, 1'b1};
    end
  end

endmodule

/* File: verilog/aux_timer_pkg.sv */
// Shared constants for the auxiliary interrupt and counter/timer block
package aux_timer_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the four-bit CPU address
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_AUX_CTRL = 4'h4; // Write: auxiliary_control
  localparam logic [3:0] ADDR_IN_CHANGE = 4'h4; // Read: input_change_register
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5; // Write: interrupt_mask
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5; // Read: interrupt_status
  localparam logic [3:0] ADDR_PRESET_UP = 4'h6; // Write: count_preset_upper
  localparam logic [3:0] ADDR_VALUE_UP = 4'h6; // Read: count_value_upper
  localparam logic [3:0] ADDR_PRESET_LO = 4'h7; // Write: count_preset_lower
  localparam logic [3:0] ADDR_VALUE_LO = 4'h7; // Read: count_value_lower
  localparam logic [3:0] ADDR_PIN_SEL = 4'hD; // Write: output_pin_source_select
  localparam logic [3:0] ADDR_OUT_SET = 4'hE; // Write: set output_register bits
  localparam logic [3:0] ADDR_OUT_CLR = 4'hF; // Write: clear output_register bits
  localparam logic [3:0] ADDR_CT_START = 4'hE; // Read: start counter command
  localparam logic [3:0] ADDR_CT_STOP = 4'hF; // Read: stop counter command

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_CTRL_RST = 8'h60; // Timer mode, crystal source
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] PIN_SEL_RST = 8'h00;
  localparam logic [7:0] OUT_REG_RST = 8'h00;
  localparam logic [15:0] PRESET_RST = 16'h0002; // Smallest legal preset
  localparam logic [15:0] CT_ONE = 16'h0001; // Last count of a half period
  localparam logic [3:0] PRESCALE_LAST = 4'hF; // Divide-by-16 wrap value

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUX_BAUD_SET = 7; // Baud-rate set select
  localparam int AUX_MODE_LSB = 4; // Counter/timer mode and source
  localparam int AUX_MODE_MSB = 6; // High bit set means timer mode
  localparam int ST_IN_CHANGE = 7;
  localparam int ST_B_BREAK = 6;
  localparam int ST_B_RX = 5;
  localparam int ST_B_TX = 4;
  localparam int ST_CT_READY = 3;
  localparam int ST_A_BREAK = 2;
  localparam int ST_A_RX = 1;
  localparam int ST_A_TX = 0;
  localparam int SEL_PIN4 = 4; // One bit for output pin 4
  localparam int SEL_PIN3_LSB = 2; // Two bits for output pin 3
  localparam int SEL_PIN2_LSB = 0; // Two bits for output pin 2

  // ----------------------------------------------------------------
  // Counter run state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CT_STOPPED = 2'b01,
    CT_COUNTING = 2'b10
  } ct_state_t;

endpackage

/* File: verilog/pin_sense_if.sv */
// Carrier for synchronised input pin levels and their change pulses
`timescale 1ns/1ps
interface pin_sense_if;
  logic [3:0] level; // Synchronised pin levels
  logic [3:0] change; // One-cycle pulse per transition
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface

/* File: verilog/input_change_detect.sv */
// Synchroniser and change-of-state detector for input pins 0 to 3
`timescale 1ns/1ps
module input_change_detect (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pins
  input wire logic [3:0] pin_i,
  // Synchronised result
  pin_sense_if.src sense
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0] meta_q; // First stage, read only by the second stage
  logic [3:0] sync_q; // Second stage, safe to use
  logic [3:0] last_q; // Previous safe level for edge finding

  // ----------------------------------------------------------------
  // Three stages per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      // A lone transition yields exactly one change pulse
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
          last_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= pin_i[g];
          sync_q[g] <= meta_q[g];
          last_q[g] <= sync_q[g];
        end
      end
    end
  endgenerate

  assign sense.level = sync_q;
  assign sense.change = sync_q ^ last_q;

endmodule

/* File: verification/serial_core_model.sv */
// Behavioural model of the two serial channel cores
`timescale 1ns/1ps
module serial_core_model (
  // Clock
  input wire logic clk_i,
  // Levels and pulses, bit 0 is channel A
  output logic [1:0] tx_ready_o,
  output logic [1:0] brk_edge_o,
  output logic [1:0] brk_clr_o,
  output logic [1:0] push_o,
  output logic [1:0] pop_o,
  output logic [1:0] full_o,
  output logic [1:0] nonempty_o,
  output logic [1:0] full_mode_o,
  // Bit clocks
  output logic [1:0] tx1_clk_o,
  output logic [1:0] rx1_clk_o,
  output logic tx16_clk_o
);
  logic [3:0] div_q = 4'h0; // Idle bit clocks run free
  logic b_tx1_q = 1'b0; // Channel B clock, stepped on demand
  // Free clocks step off the sampling edge
  always @(negedge clk_i) begin
    div_q <= div_q + 4'h1;
  end
  assign tx16_clk_o = div_q[0];
  assign tx1_clk_o = {b_tx1_q, div_q[3]};
  assign rx1_clk_o = {div_q[2], div_q[3]};
  // Quiet levels at start
  initial {tx_ready_o, brk_edge_o, brk_clr_o, push_o, pop_o, full_o, nonempty_o,
           full_mode_o} = 16'h0000;
  // Ready, full, nonempty, full mode
  task automatic levels(input logic [7:0] l);
    @(negedge clk_i);
    {tx_ready_o, full_o, nonempty_o, full_mode_o} = l;
  endtask
  // One-cycle push, break edge, break clear, pop
  task automatic pulse(input logic [7:0] p);
    @(negedge clk_i);
    {push_o, brk_edge_o, brk_clr_o, pop_o} = p;
    @(negedge clk_i);
    {push_o, brk_edge_o, brk_clr_o, pop_o} = 8'h00;
    repeat (3) @(negedge clk_i);
  endtask
  // Rising edges of channel B transmit clock
  task automatic tick_b(input int k);
    repeat (k) begin
      @(negedge clk_i);
      b_tx1_q = 1'b1;
      @(negedge clk_i);
      b_tx1_q = 1'b0;
    end
    repeat (3) @(negedge clk_i);
  endtask
endmodule

/* File: verification/aux_timer_chk.sv */
// Port checker for the auxiliary timer block
`timescale 1ns/1ps
module aux_timer_chk
  import aux_timer_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register bus
  input wire logic [3:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_rdata_o,
  // Pins and status
  input wire logic [3:0] input_pin_i,
  input wire logic ch_a_tx_ready_i,
  input wire logic ch_b_tx_ready_i,
  input wire logic interrupt_out_n_o,
  input wire logic [2:0] output_pin_o,
  input wire logic [7:0] output_register_o
);
  logic [7:0] sel_q; // Copy of pin select
  logic [7:0] mask_q; // Copy of mask
  logic [3:0] h1_q, h2_q, h3_q; // Pin history spans the sync delay
  wire quiet = (input_pin_i == h1_q) && (h1_q == h2_q) && (h2_q == h3_q);
  // Shadows follow bus writes
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= 8'h00;
      mask_q <= 8'h00;
      {h1_q, h2_q, h3_q} <= 12'h000;
    end else begin
      if (cpu_wr_i && cpu_addr_i == ADDR_PIN_SEL) sel_q <= cpu_wdata_i;
      if (cpu_wr_i && cpu_addr_i == ADDR_IRQ_MASK) mask_q <= cpu_wdata_i;
      {h1_q, h2_q, h3_q} <= {input_pin_i, h1_q, h2_q};
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_start_rd_zero: assert property (
    cpu_rd_i && cpu_addr_i == ADDR_CT_START |=> cpu_rdata_o == 8'h00) else $error("start data");
  a_stop_rd_zero: assert property (
    cpu_rd_i && cpu_addr_i == ADDR_CT_STOP |=> cpu_rdata_o == 8'h00) else $error("stop data");
  a_out_set_or: assert property (cpu_wr_i && cpu_addr_i == ADDR_OUT_SET |=>
    output_register_o == ($past(output_register_o) | $past(cpu_wdata_i))) else $error("set");
  a_out_clr_and: assert property (cpu_wr_i && cpu_addr_i == ADDR_OUT_CLR |=>
    output_register_o == ($past(output_register_o) & ~$past(cpu_wdata_i))) else $error("clr");
  a_pin3_opr: assert property ($past(sel_q[3:2]) == 2'b00 |->
    output_pin_o[1] == !$past(output_register_o[3])) else $error("pin 3 source");
  a_pin4_opr: assert property (!$past(sel_q[4]) |->
    output_pin_o[2] == !$past(output_register_o[4])) else $error("pin 4 source");
  a_irq_mask_off: assert property (
    $past(mask_q) == 8'h00 |-> interrupt_out_n_o) else $error("masked irq");
  a_tx_mirror: assert property ($past(mask_q) == 8'h11 |-> interrupt_out_n_o ==
    !($past(ch_a_tx_ready_i) || $past(ch_b_tx_ready_i))) else $error("tx ready irq");
  a_live_level: assert property (cpu_rd_i && cpu_addr_i == ADDR_IN_CHANGE && quiet
    |=> cpu_rdata_o[3:0] == $past(input_pin_i)) else $error("live level");
  c_start: cover property (cpu_rd_i && cpu_addr_i == ADDR_CT_START);
  c_irq: cover property (!interrupt_out_n_o);
  c_wave: cover property (!output_pin_o[1] ##1 output_pin_o[1]);
endmodule
bind uart_aux_irq_timer_ctrl aux_timer_chk u_chk (.*);

/* File: verification/uart_aux_irq_timer_ctrl_tb_top.sv */
// Self-checking bench for the auxiliary timer block
`timescale 1ns/1ps
module uart_aux_irq_timer_ctrl_tb_top;
  import aux_timer_pkg::*;
  logic clk = 1'b0; // 25 MHz core clock
  logic rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] pins = 4'h0; // Low through reset, no stale change
  logic [7:0] rdata, oreg, v;
  logic [2:0] opin, oe;
  logic irq_n, baud, tx16;
  logic [1:0] rdy, bedge, bclr, push, pop, full, nonempty, fmode, tx1, rx1;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  always #20 clk = ~clk;
  uart_aux_irq_timer_ctrl u_dut (
    .core_clk_i(clk), .rstn_i(rstn), .cpu_addr_i(addr), .cpu_wdata_i(wdata),
    .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_rdata_o(rdata), .input_pin_i(pins),
    .ch_a_tx_ready_i(rdy[0]), .ch_b_tx_ready_i(rdy[1]),
    .ch_a_break_edge_i(bedge[0]), .ch_b_break_edge_i(bedge[1]),
    .ch_a_break_clr_i(bclr[0]), .ch_b_break_clr_i(bclr[1]),
    .ch_a_rx_push_i(push[0]), .ch_b_rx_push_i(push[1]),
    .ch_a_rx_pop_i(pop[0]), .ch_b_rx_pop_i(pop[1]),
    .ch_a_fifo_full_i(full[0]), .ch_b_fifo_full_i(full[1]),
    .ch_a_fifo_nonempty_i(nonempty[0]), .ch_b_fifo_nonempty_i(nonempty[1]),
    .ch_a_full_mode_i(fmode[0]), .ch_b_full_mode_i(fmode[1]),
    .ch_a_tx16_clk_i(tx16), .ch_a_tx1_clk_i(tx1[0]), .ch_a_rx1_clk_i(rx1[0]),
    .ch_b_tx1_clk_i(tx1[1]), .ch_b_rx1_clk_i(rx1[1]),
    .interrupt_out_n_o(irq_n), .output_pin_o(opin), .output_pin_oe_o(oe),
    .output_register_o(oreg), .baud_set_two_o(baud)
  );
  serial_core_model u_core (
    .clk_i(clk), .tx_ready_o(rdy), .brk_edge_o(bedge), .brk_clr_o(bclr), .push_o(push),
    .pop_o(pop), .full_o(full), .nonempty_o(nonempty), .full_mode_o(fmode),
    .tx1_clk_o(tx1), .rx1_clk_o(rx1), .tx16_clk_o(tx16)
  );
  // Compare one result
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  // One-cycle write strobe, then settle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  wire [7:0] p3 = {6'h0, opin[1], oe[1]}, p4 = {6'h0, opin[2], oe[2]}, iq = {7'h0, irq_n};
  // One-cycle read; data kept until the next read
  task automatic rd_reg(input logic [3:0] a);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic rd_chk(input string w, input logic [3:0] a, input logic [7:0] e);
    rd_reg(a);
    chk(w, e, v);
  endtask
  // Status read under a mask
  task automatic st(input logic [7:0] m, e);
    rd_reg(ADDR_IRQ_STATUS);
    chk("status", e, v & m);
  endtask
  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog: about 250 cycles needed
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (14) @(negedge clk);
    st(8'hFF, 8'h08);
    for (int m = 0; m < 8; m++) begin
      wr_reg(ADDR_AUX_CTRL, {m[0], m[2:0], 4'h0});
      chk("baud", {7'h0, m[0]}, {7'h0, baud});
    end
    // Counter mode, B clock
    wr_reg(ADDR_AUX_CTRL, 8'h20);
    wr_reg(ADDR_PRESET_UP, 8'h00);
    wr_reg(ADDR_PRESET_LO, 8'h05);
    wr_reg(ADDR_PIN_SEL, 8'h14);
    rd_reg(ADDR_CT_STOP);
    rd_reg(ADDR_CT_START);
    u_core.tick_b(3);
    rd_reg(ADDR_CT_STOP);
    rd_chk("count lo", ADDR_VALUE_LO, 8'h02);
    chk("pin 3", 8'h02, p3);
    st(8'hFF, 8'h00);
    rd_reg(ADDR_CT_START);
    u_core.tick_b(5);
    st(8'hFF, 8'h08);
    chk("pin 3", 8'h01, p3);
    wr_reg(ADDR_PRESET_LO, 8'h09);
    u_core.tick_b(2);
    rd_reg(ADDR_CT_STOP);
    rd_chk("count hi", ADDR_VALUE_UP, 8'hFF);
    rd_chk("count lo", ADDR_VALUE_LO, 8'hFE);
    st(8'hFF, 8'h00);
    chk("pin 3", 8'h02, p3);
    rd_reg(ADDR_CT_START);
    u_core.tick_b(3);
    rd_reg(ADDR_CT_STOP);
    rd_chk("count lo", ADDR_VALUE_LO, 8'h06);
    // Timer wave
    wr_reg(ADDR_AUX_CTRL, 8'h60);
    wr_reg(ADDR_PRESET_LO, 8'h03);
    rd_reg(ADDR_CT_START);
    for (n = 0; n < 20 && opin[1] !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 20 && opin[1] !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 20 && opin[1] === 1'b1; n++) @(negedge clk);
    chk("half period", 8'h03, n[7:0]);
    // Pins 0,1 change; pin 0 enabled
    wr_reg(ADDR_AUX_CTRL, 8'h61);
    wr_reg(ADDR_IRQ_MASK, 8'h80);
    pins = 4'h2;
    repeat (6) @(negedge clk);
    st(8'h80, 8'h00);
    chk("irq", 8'h01, iq);
    pins = 4'h3;
    repeat (6) @(negedge clk);
    chk("irq", 8'h00, iq);
    rd_chk("input_change_and_level", ADDR_IN_CHANGE, 8'h33);
    rd_chk("input_change_and_level", ADDR_IN_CHANGE, 8'h03);
    chk("irq", 8'h01, iq);
    // Channel status bits
    wr_reg(ADDR_IRQ_MASK, 8'h11);
    u_core.levels(8'hC0);
    repeat (2) @(negedge clk);
    chk("irq", 8'h00, iq);
    st(8'h77, 8'h11);
    u_core.levels(8'h00);
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    u_core.pulse(8'h40);
    st(8'h77, 8'h02);
    chk("pin 4", 8'h01, p4);
    u_core.pulse(8'h01);
    st(8'h77, 8'h00);
    chk("pin 4", 8'h02, p4);
    u_core.pulse(8'h30);
    st(8'h77, 8'h44);
    u_core.pulse(8'h0C);
    st(8'h77, 8'h00);
    u_core.levels(8'h01);
    u_core.pulse(8'h40);
    st(8'h77, 8'h00);
    // Full mode: channel A FIFO full during the push
    u_core.levels(8'h11);
    u_core.pulse(8'h40);
    st(8'h77, 8'h02);
    wr_reg(ADDR_OUT_SET, 8'h1C);
    wr_reg(ADDR_OUT_CLR, 8'h0C);
    chk("out reg", 8'h10, oreg);
    final_report();
  end
endmodule
